// >>> cdr_pkg.sv
// Constants, field layouts and carrier types of the current DAC register set
package cdr_pkg;
    // Frame and address byte codes
    localparam logic [4:0] FRAME_BITS = 5'd24;
    localparam logic [4:0] BIT_CNT_MAX = 5'd25;
    localparam logic [7:0] ADDR_NOP = 8'h00;
    localparam logic [7:0] ADDR_CODE = 8'h01;
    localparam logic [7:0] ADDR_READ = 8'h02;
    localparam logic [7:0] ADDR_CFG = 8'h55;
    localparam logic [7:0] ADDR_RESET = 8'h56;
    localparam int RESET_BIT = 0;

    // Read selector values
    localparam logic [1:0] SEL_STATUS = 2'h0;
    localparam logic [1:0] SEL_CODE = 2'h1;
    localparam logic [1:0] SEL_CFG = 2'h2;

    // Resolution: 16 for the wide variant, 12 drops the low four code bits
    localparam int CODE_BITS = 16;
    localparam logic [15:0] CODE_MASK = 16'(16'hffff << (16 - CODE_BITS));
    localparam logic [15:0] CFG_MASK = 16'h3fff;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Span codes and loop currents in microamps
    localparam logic [2:0] SPAN_4_20 = 3'h5;
    localparam logic [2:0] SPAN_0_20 = 3'h6;
    localparam logic [2:0] SPAN_0_24 = 3'h7;
    localparam logic [14:0] UA_SPAN_16 = 15'd16000;
    localparam logic [14:0] UA_SPAN_20 = 15'd20000;
    localparam logic [14:0] UA_SPAN_24 = 15'd24000;
    localparam logic [14:0] UA_OFFSET_4 = 15'd4000;
    localparam logic [14:0] UA_ZERO = 15'd0;

    // Clock and timing
    localparam int SYS_HZ = 20000000;
    localparam int SYS_PERIOD_NS = 50;
    localparam int SETTLE_NS = 40000;
    localparam int SETTLE_CYC = (SETTLE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [9:0] SETTLE_LAST = 10'(SETTLE_CYC - 1);
    localparam int RAMP_HZ [16] = '{257730, 198410, 152440, 131580, 115740, 69440, 37590,
        25770, 20160, 16030, 10290, 8280, 6900, 5530, 4240, 3300};

    // Trim words fetched after every reset; values are arbitrary
    localparam int TRIM_WORDS = 2;
    localparam logic [15:0] TRIM_ROM [TRIM_WORDS] = '{16'h8000, 16'h0000};

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } cdr_frame_s;

    typedef struct packed {
        logic [1:0] zero;
        logic ext_resistor_select;
        logic output_drive_enable;
        logic [3:0] ramp_update_rate;
        logic [2:0] ramp_increment;
        logic ramp_enable;
        logic chain_mode_enable;
        logic [2:0] span_select;
    } cdr_cfg_s;

    typedef enum logic [1:0] {
        TRIM_FETCH = 2'b00,
        TRIM_SETTLE = 2'b01,
        TRIM_READY = 2'b10
    } cdr_trim_e;
endpackage

// >>> cdr_top.sv
// Serial register set, command decode and output control of the current DAC
// Notes on behaviour
// [R01] Read frame: address 02, low two bits select
// [R02] Power-on clears all registers, output disabled
// [R03] Trim values fetched and applied after reset
// [R04] Host waits 40 us before trusting output
// [R05] Host sends reset if supplies ramp slowly
// [R06] Current proportional to code, span plus offset
// [R07] Address 01 writes code, variant masks bits
// [R08] Address 55 writes whole configuration word
// [R09] Configuration field layout, top bits zero
// [R10] Host sets resistor select with enable
// [R11] Output driven only while enable bit set
// [R12] Span codes 101, 110, 111 pick ranges
// [R13] Address 56 with bit 0 resets all
// [R14] Status read-only: fault, ramp, overtemp flags
// [R15] Fault flag follows loop output fault
// [R16] Ramp flag while slewing toward target
// [R17] Overtemp flag follows die temperature alarm
// [R18] 24-bit frame, MSB first, load on strobe
// [R19] Selector 00 status, 01 code, 10 config
// [R20] Following NOP frame shifts register out
// [R21] Unknown address bytes change nothing
`timescale 1ns/1ps
module cdr_top
    import cdr_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic SER_CLK,
    input wire logic SER_DIN,
    input wire logic LOAD_STROBE,
    input wire logic LOOP_FAULT_IN,
    input wire logic OVER_TEMP_IN,
    output logic SER_DOUT,
    output logic SER_DOUT_OE_N,
    output logic OUTPUT_DRIVE_ENABLE,
    output logic EXT_RESISTOR_SELECT,
    output logic CHAIN_MODE_ENABLE,
    output logic [2:0] SPAN_SELECT,
    output logic [15:0] LOOP_CODE,
    output logic [14:0] LOOP_CURRENT_UA,
    output logic [15:0] TRIM_GAIN,
    output logic [15:0] TRIM_OFFSET,
    output logic CAL_READY
);
    logic [2:0] sclk_s_q;
    logic [1:0] din_s_q;
    logic [2:0] load_s_q;
    logic [1:0] fault_s_q;
    logic [1:0] temp_s_q;
    logic sclk_rise;
    logic sclk_fall;
    logic load_rise;
    logic rst;
    logic soft_rst_q;
    logic [23:0] shreg_q;
    logic [4:0] bit_cnt_q;
    logic frame_ok;
    cdr_frame_s frame;
    logic addr_known;
    logic [15:0] code_q;
    cdr_cfg_s cfg_q;
    logic [15:0] status;
    logic [15:0] rd_word;
    logic [23:0] rd_sh_q;
    logic rd_en_q;
    logic chain_bit_q;
    logic [15:0] cur_q;
    logic ramp_q;
    logic [12:0] div_q;
    logic [16:0] step;
    logic [16:0] gap_up;
    logic [16:0] gap_dn;
    logic [14:0] span_ua;
    logic [14:0] offset_ua;
    logic [30:0] prod;
    cdr_trim_e trim_q;
    logic trim_idx_q;
    logic [9:0] settle_q;

    function automatic logic [12:0] ramp_div(input logic [3:0] r);
        ramp_div = 13'(SYS_HZ / RAMP_HZ[r] - 1);
    endfunction

    // Pin synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            sclk_s_q <= 3'h0;
            din_s_q <= 2'h0;
            load_s_q <= 3'h0;
            fault_s_q <= 2'h0;
            temp_s_q <= 2'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], SER_CLK};
            din_s_q <= {din_s_q[0], SER_DIN};
            load_s_q <= {load_s_q[1:0], LOAD_STROBE};
            fault_s_q <= {fault_s_q[0], LOOP_FAULT_IN};
            temp_s_q <= {temp_s_q[0], OVER_TEMP_IN};
        end
    end

    assign sclk_rise = sclk_s_q[1] && !sclk_s_q[2];
    assign sclk_fall = !sclk_s_q[1] && sclk_s_q[2];
    assign load_rise = load_s_q[1] && !load_s_q[2];
    assign rst = !RESET_N || soft_rst_q;

    // Frame capture; wrong edge counts make the frame void
    always_ff @(posedge SYS_CLK) begin
        if (rst) begin
            shreg_q <= 24'h0;
            bit_cnt_q <= 5'h0;
        end else if (load_rise) begin
            bit_cnt_q <= 5'h0; // [R18]
        end else if (sclk_rise) begin
            shreg_q <= {shreg_q[22:0], din_s_q[1]}; // [R18]
            if (cfg_q.chain_mode_enable && bit_cnt_q == FRAME_BITS) begin
                bit_cnt_q <= 5'h1; // Chained frames are whole multiples of 24 bits [R18]
            end else if (bit_cnt_q != BIT_CNT_MAX) begin
                bit_cnt_q <= bit_cnt_q + 5'h1;
            end
        end
    end

    assign frame = cdr_frame_s'(shreg_q);
    assign frame_ok = load_rise && bit_cnt_q == FRAME_BITS; // [R18]
    assign addr_known = frame.addr == ADDR_NOP || frame.addr == ADDR_CODE // [R21]
        || frame.addr == ADDR_READ || frame.addr == ADDR_CFG || frame.addr == ADDR_RESET;

    // One-cycle reset command pulse; its register is reset only by the pin reset
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= frame_ok && frame.addr == ADDR_RESET && frame.data[RESET_BIT]; // [R13]
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (rst) begin
            code_q <= REG_RESET; // [R02]
        end else if (frame_ok && frame.addr == ADDR_CODE) begin
            code_q <= frame.data & CODE_MASK; // [R07]
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (rst) begin
            cfg_q <= cdr_cfg_s'(REG_RESET); // [R02]
        end else if (frame_ok && frame.addr == ADDR_CFG) begin
            cfg_q <= cdr_cfg_s'(frame.data & CFG_MASK); // [R08] [R09]
        end
    end

    // Status and readback selection
    assign status = {13'h0, fault_s_q[1], ramp_q, temp_s_q[1]}; // [R14] [R15] [R17]

    always_comb begin
        case (frame.data[1:0]) // [R01] [R19]
            SEL_STATUS: rd_word = status;
            SEL_CODE: rd_word = code_q;
            SEL_CFG: rd_word = cfg_q;
            default: rd_word = REG_RESET;
        endcase
    end

    // Readback shifter, armed by a read frame, dropped by the next load
    always_ff @(posedge SYS_CLK) begin
        if (rst) begin
            rd_sh_q <= 24'h0;
            rd_en_q <= 1'b0;
        end else if (frame_ok && frame.addr == ADDR_READ) begin
            rd_sh_q <= {8'h00, rd_word}; // [R01]
            rd_en_q <= 1'b1; // [R20]
        end else if (load_rise) begin
            rd_en_q <= 1'b0; // [R20]
        end else if (sclk_fall && rd_en_q) begin
            rd_sh_q <= {rd_sh_q[22:0], 1'b0}; // [R20]
        end
    end

    // Chain output leaves on the falling edge so it is steady at the next rise
    always_ff @(posedge SYS_CLK) begin
        if (rst) begin
            chain_bit_q <= 1'b0;
        end else if (sclk_fall) begin
            chain_bit_q <= shreg_q[23];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (rst) begin
            SER_DOUT <= 1'b0;
            SER_DOUT_OE_N <= 1'b1;
        end else begin
            SER_DOUT <= cfg_q.chain_mode_enable ? chain_bit_q : rd_sh_q[23];
            SER_DOUT_OE_N <= !(cfg_q.chain_mode_enable || rd_en_q); // [R20]
        end
    end

    // Slew engine; disabled slew jumps straight to the code
    assign step = 17'(17'h1 << cfg_q.ramp_increment);
    assign gap_up = {1'b0, code_q} - {1'b0, cur_q};
    assign gap_dn = {1'b0, cur_q} - {1'b0, code_q};

    always_ff @(posedge SYS_CLK) begin
        if (rst) begin
            cur_q <= REG_RESET;
            div_q <= 13'h0;
        end else if (!cfg_q.ramp_enable) begin
            cur_q <= code_q;
            div_q <= 13'h0;
        end else if (div_q >= ramp_div(cfg_q.ramp_update_rate)) begin
            div_q <= 13'h0;
            if (code_q > cur_q) begin
                cur_q <= gap_up > step ? 16'({1'b0, cur_q} + step) : code_q;
            end else if (code_q < cur_q) begin
                cur_q <= gap_dn > step ? 16'({1'b0, cur_q} - step) : code_q;
            end
        end else begin
            div_q <= div_q + 13'h1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (rst) begin
            ramp_q <= 1'b0;
        end else begin
            ramp_q <= cfg_q.ramp_enable && cur_q != code_q; // [R16]
        end
    end

    // Output stage; undefined span codes give no current
    always_comb begin
        case (cfg_q.span_select) // [R12]
            SPAN_4_20: begin
                span_ua = UA_SPAN_16;
                offset_ua = UA_OFFSET_4;
            end
            SPAN_0_20: begin
                span_ua = UA_SPAN_20;
                offset_ua = UA_ZERO;
            end
            SPAN_0_24: begin
                span_ua = UA_SPAN_24;
                offset_ua = UA_ZERO;
            end
            default: begin
                span_ua = UA_ZERO;
                offset_ua = UA_ZERO;
            end
        endcase
    end

    assign prod = 31'(span_ua) * 31'(cur_q); // [R06]

    always_ff @(posedge SYS_CLK) begin
        if (rst) begin
            LOOP_CURRENT_UA <= UA_ZERO;
            OUTPUT_DRIVE_ENABLE <= 1'b0;
            EXT_RESISTOR_SELECT <= 1'b0;
            CHAIN_MODE_ENABLE <= 1'b0;
            SPAN_SELECT <= 3'h0;
            LOOP_CODE <= REG_RESET;
        end else begin
            LOOP_CURRENT_UA <= cfg_q.output_drive_enable
                ? offset_ua + prod[30:16] : UA_ZERO; // [R06] [R11]
            OUTPUT_DRIVE_ENABLE <= cfg_q.output_drive_enable; // [R11]
            EXT_RESISTOR_SELECT <= cfg_q.ext_resistor_select;
            CHAIN_MODE_ENABLE <= cfg_q.chain_mode_enable;
            SPAN_SELECT <= cfg_q.span_select;
            LOOP_CODE <= cur_q;
        end
    end

    // Trim fetch and settle after every reset
    always_ff @(posedge SYS_CLK) begin
        if (rst) begin
            trim_q <= TRIM_FETCH;
            trim_idx_q <= 1'b0;
            settle_q <= 10'h0;
            TRIM_GAIN <= REG_RESET;
            TRIM_OFFSET <= REG_RESET;
            CAL_READY <= 1'b0;
        end else begin
            case (trim_q)
                TRIM_FETCH: begin
                    if (!trim_idx_q) begin
                        TRIM_GAIN <= TRIM_ROM[0]; // [R03]
                        trim_idx_q <= 1'b1;
                    end else begin
                        TRIM_OFFSET <= TRIM_ROM[1]; // [R03]
                        trim_q <= TRIM_SETTLE;
                    end
                end
                TRIM_SETTLE: begin
                    if (settle_q == SETTLE_LAST) begin
                        trim_q <= TRIM_READY; // [R04]
                        CAL_READY <= 1'b1;
                    end else begin
                        settle_q <= settle_q + 10'h1;
                    end
                end
                TRIM_READY: CAL_READY <= 1'b1;
                default: trim_q <= TRIM_FETCH;
            endcase
        end
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    chk_cfg_top_zero: assert property (cfg_q.zero == 2'h0) // [R09]
        else $error("configuration top bits not zero");
    chk_soft_reset_clear: assert property ( // [R13]
        soft_rst_q |=> code_q == 16'h0 && cfg_q == 16'h0 && !CAL_READY)
        else $error("reset command left state behind");
    chk_code_write: assert property ( // [R07]
        frame_ok && frame.addr == ADDR_CODE |=> code_q == ($past(frame.data) & CODE_MASK))
        else $error("code write not stored");
    chk_cfg_write: assert property ( // [R08]
        frame_ok && frame.addr == ADDR_CFG |=> cfg_q == ($past(frame.data) & CFG_MASK))
        else $error("configuration write not stored");
    chk_bad_addr_ignored: assert property ( // [R21]
        frame_ok && !addr_known |=> $stable(code_q) && $stable(cfg_q))
        else $error("unknown address changed a register");
    chk_drive_gate: assert property ( // [R11]
        !cfg_q.output_drive_enable |=> LOOP_CURRENT_UA == UA_ZERO && !OUTPUT_DRIVE_ENABLE)
        else $error("current driven while disabled");
    chk_span_offset: assert property ( // [R12]
        cfg_q.output_drive_enable && cfg_q.span_select == SPAN_4_20 && cur_q == 16'h0 && !rst
        |=> LOOP_CURRENT_UA == UA_OFFSET_4)
        else $error("four milliamp offset missing");
    chk_ramp_flag: assert property ( // [R16]
        cfg_q.ramp_enable && cur_q != code_q && !rst |=> status[1])
        else $error("ramp flag not raised");
    chk_read_select: assert property ( // [R19]
        frame_ok && frame.addr == ADDR_READ && frame.data[1:0] == SEL_CFG
        |=> rd_en_q && rd_sh_q[15:0] == $past(cfg_q))
        else $error("readback word wrong");
    chk_settle_time: assert property ($rose(trim_q == TRIM_SETTLE) |-> !CAL_READY [*8]) // [R04]
        else $error("calibration ready too early");
endmodule

// >>> cdr_host.sv
// Host-side serial master model for the current DAC register set
`timescale 1ns/1ps
module cdr_host
(
    input wire logic sys_clk,
    input wire logic ser_dout,
    output logic ser_clk,
    output logic ser_din,
    output logic load_strobe
);
    initial begin
        ser_clk = 1'h0;
        ser_din = 1'h0;
        load_strobe = 1'h0;
    end

    task automatic wait_neg(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Clock stands low outside frames; edges below 24 give a short frame
    task automatic xfer(input logic [23:0] frame, input int edges, output logic [23:0] rx);
        rx = 24'h0;
        for (int i = edges - 1; i >= 0; i--) begin
            ser_din = frame[i % 24];
            wait_neg(4);
            rx = {rx[22:0], ser_dout};
            ser_clk = 1'h1;
            wait_neg(4);
            ser_clk = 1'h0;
        end
        // Data line no longer meaningful, so it flips rather than holding
        ser_din = ~ser_din;
        wait_neg(4);
        load_strobe = 1'h1;
        wait_neg(4);
        load_strobe = 1'h0;
        wait_neg(6);
    endtask
endmodule

// >>> tb_cdr_top.sv
// Self-checking bench for the current DAC register set
`timescale 1ns/1ps
module tb_cdr_top;
    import cdr_pkg::*;
    logic sys_clk = 1'h0;
    logic reset_n, ser_clk, ser_din, load_strobe, fault_in, temp_in;
    logic ser_dout, oe_n, drv_en, ext_sel, chain_en, cal_ready;
    logic [2:0] span;
    logic [15:0] loop_code, trim_gain, trim_off, cfg, code;
    logic [14:0] ua;
    logic [23:0] rx;
    int err_count, total_checks, cycles;

    always #25 sys_clk = ~sys_clk;

    cdr_top dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .SER_CLK(ser_clk), .SER_DIN(ser_din),
        .LOAD_STROBE(load_strobe), .LOOP_FAULT_IN(fault_in), .OVER_TEMP_IN(temp_in),
        .SER_DOUT(ser_dout), .SER_DOUT_OE_N(oe_n), .OUTPUT_DRIVE_ENABLE(drv_en),
        .EXT_RESISTOR_SELECT(ext_sel), .CHAIN_MODE_ENABLE(chain_en), .SPAN_SELECT(span),
        .LOOP_CODE(loop_code), .LOOP_CURRENT_UA(ua), .TRIM_GAIN(trim_gain),
        .TRIM_OFFSET(trim_off), .CAL_READY(cal_ready));

    cdr_host host (.sys_clk(sys_clk), .ser_dout(ser_dout), .ser_clk(ser_clk),
        .ser_din(ser_din), .load_strobe(load_strobe));

    task automatic finish_test;
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [15:0] data);
        host.xfer({addr, data}, 24, rx);
    endtask

    task automatic rd(input logic [1:0] sel, input logic [15:0] exp);
        host.xfer({ADDR_READ, 14'($urandom()), sel}, 24, rx);
        chk({15'h0, oe_n}, 16'h0);
        host.xfer(24'h0, 24, rx);
        chk(rx[15:0], exp);
        chk({15'h0, oe_n}, 16'h1);
    endtask

    task automatic wait_cal;
        for (int n = 0; n < 1000 && cal_ready !== 1'h1; n++) @(negedge sys_clk);
        chk({15'h0, cal_ready}, 16'h1);
        chk(trim_gain, TRIM_ROM[0]);
        chk(trim_off, TRIM_ROM[1]);
    endtask

    function automatic logic [15:0] exp_ua(input logic [15:0] c, input logic [15:0] d);
        logic [31:0] p;
        p = 32'h0;
        if (c[12]) begin
            case (c[2:0])
                SPAN_4_20: p = 32'(UA_OFFSET_4) + ((32'(UA_SPAN_16) * 32'(d)) >> 16);
                SPAN_0_20: p = (32'(UA_SPAN_20) * 32'(d)) >> 16;
                SPAN_0_24: p = (32'(UA_SPAN_24) * 32'(d)) >> 16;
                default: p = 32'h0;
            endcase
        end
        return p[15:0];
    endfunction

    // Hang guard, generous against roughly 20k cycles of traffic
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        reset_n = 1'h0;
        fault_in = 1'h0;
        temp_in = 1'h0;
        void'($urandom(52));
        repeat (20) @(negedge sys_clk);
        reset_n = 1'h1;
        chk({13'h0, oe_n, drv_en, cal_ready}, 16'h0004);
        chk(loop_code, 16'h0);
        for (int s = 0; s < 3; s++) rd(2'(s), 16'h0);
        wait_cal();
        for (int i = 0; i < 10; i++) begin
            // Ramp and chain off; enable set in every write, so resistor select is safe
            cfg = (16'($urandom()) & 16'hffe7) | 16'h1000;
            cfg[2:0] = 3'h5 + 3'(i % 3);
            code = (i == 0) ? 16'hffff : (i == 1) ? 16'h0 : 16'($urandom());
            wr(ADDR_CFG, cfg);
            wr(ADDR_CODE, code);
            chk({drv_en, ext_sel, chain_en, 10'h0, span},
                {cfg[12], cfg[13], cfg[3], 10'h0, cfg[2:0]});
            chk(loop_code, code & CODE_MASK);
            chk({1'h0, ua}, exp_ua(cfg, code & CODE_MASK));
            rd(SEL_CFG, cfg & CFG_MASK);
            rd(SEL_CODE, code & CODE_MASK);
        end
        wr(8'h33, 16'hffff);
        host.xfer({ADDR_CODE, ~code}, 23, rx);
        wr(ADDR_RESET, 16'hfffe);
        wr(ADDR_NOP, 16'hffff);
        chk(loop_code, code & CODE_MASK);
        rd(SEL_CFG, cfg & CFG_MASK);
        wr(ADDR_CFG, 16'h0007);
        chk({15'h0, drv_en}, 16'h0);
        chk({1'h0, ua}, 16'h0);
        wr(ADDR_CFG, 16'h0008);
        chk({14'h0, chain_en, oe_n}, 16'h0002);
        // Two frames' worth of edges in chain mode; the last 24 bits land
        host.xfer({ADDR_CODE, 16'h1234}, 48, rx);
        chk(loop_code, 16'h1234 & CODE_MASK);
        wr(ADDR_CFG, 16'h0000);
        chk(rx[15:0], 16'h1234);
        wr(ADDR_CODE, 16'h0000);
        fault_in = 1'h1;
        // Fastest rate, smallest step: a full-scale ramp outlasts both status reads
        wr(ADDR_CFG, 16'h1017);
        wr(ADDR_CODE, 16'hffff);
        rd(SEL_STATUS, 16'h0006);
        fault_in = 1'h0;
        temp_in = 1'h1;
        rd(SEL_STATUS, 16'h0003);
        temp_in = 1'h0;
        wr(ADDR_RESET, 16'h0001);
        chk({13'h0, oe_n, drv_en, cal_ready}, 16'h0004);
        chk(loop_code, 16'h0);
        rd(SEL_CFG, 16'h0);
        rd(SEL_STATUS, 16'h0);
        wait_cal();
        finish_test();
    end
endmodule
